// [rtl/dpot_defs.svh]
`ifndef DPOT_DEFS_SVH
`define DPOT_DEFS_SVH

// register addresses carried in the address byte
`define REG_WIPER 8'h00
`define REG_RESERVED 8'h01
`define REG_ACCESS 8'h02

// access control field positions
`define ACC_VOLATILE_BIT 7
`define ACC_SHUTDOWN_BIT 6
`define ACC_BUSY_BIT 5

// reset and fill values
`define WIPER_PRESET 7'h40
`define VOLATILE_RESET 1'h0
`define SHUTDOWN_RESET 1'h1
`define NV_BLANK 8'h00
`define READ_ZERO 8'h00

// idle pin levels {scl, sda, shutdown pin, select hi, select lo};
// link lines idle high through their pull-ups
`define PIN_IDLE 5'h1C
`define LINE_IDLE 1'h1

// serial framing: data bits per byte before the ack slot
`define BYTE_BITS 4'h8

// timing, figure in its own unit, cycles derived from the clock rate
`define CLK_KHZ 10000
`define T_WC_MS 20
`define WC_CYCLES (`T_WC_MS * `CLK_KHZ)
`define T_NVRD_US 2
`define NVRD_CYCLES ((`T_NVRD_US * `CLK_KHZ + 999) / 1000)

`endif

// [rtl/dpot_pkg.sv]
package dpot_pkg;

  // serial slave states
  typedef enum logic [5:0] {
    IDLE   = 6'h01,
    RX     = 6'h02,
    ACK    = 6'h04,
    TX     = 6'h08,
    TXACK  = 6'h10,
    TXLOAD = 6'h20
  } bus_state_t;

  // which byte of a frame is being received
  typedef enum logic [2:0] {
    PH_ID   = 3'h1,
    PH_ADDR = 3'h2,
    PH_DATA = 3'h4
  } byte_phase_t;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/100ps
`include "dpot_defs.svh"

module pin_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1;

  // two flops per pin; first stage feeds only the second;
  // reset loads idle levels so no false edge follows reset
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          stage1[i] <= RESET_VAL[i];
          pinOut[i] <= RESET_VAL[i];
        end else begin
          stage1[i] <= pinIn[i];
          pinOut[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule // pin_sync

// [rtl/nv_store.sv]
`timescale 1ns/100ps
`include "dpot_defs.svh"

module nv_store #(
  parameter int WIDTH = 8,
  parameter int WRITE_CYCLES = `WC_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // factory clear of the cell
  input wire logic nvErase,
  // write request, taken only when idle
  input wire logic writeReq,
  input wire logic [WIDTH-1:0] writeData,
  // stored value and busy flag
  output logic [WIDTH-1:0] storedData,
  output logic busy
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);
  logic [CW-1:0] cycleCnt;

  // cell is not touched by rst: contents survive a power cycle
  always_ff @(posedge ref_clk) begin
    if (nvErase) begin
      storedData <= `NV_BLANK;
    end else if (writeReq && !busy) begin
      storedData <= writeData;
    end
  end

  // self-timed write cycle; busy until the count runs out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
      cycleCnt <= '0;
    end else if (writeReq && !busy) begin
      busy <= 1'b1;
      cycleCnt <= CW'(WRITE_CYCLES - 1);
    end else if (busy) begin
      if (cycleCnt == '0) begin
        busy <= 1'b0;
      end else begin
        cycleCnt <= cycleCnt - 1'b1;
      end
    end
  end

endmodule // nv_store

// [rtl/dpot_ctrl.sv]
`timescale 1ns/100ps
`include "dpot_defs.svh"

// Contract
// - code 127 nearest high, 0 nearest low
// - shutdown unless pin and control bit high
// - leaving shutdown restores the held tap
// - serial access works during shutdown
// - sample on scl rise, drive after fall
// - data line open drain, pull-low only
// - address low bits must match select pins
// - power-up presets wiper to 40h
// - then wiper reloads from initial store
// - seven-bit wiper, monotonic 00h to 7Fh
// - address 0 wiper, 1 reserved, 2 control
// - control bit 7 picks volatile or store
// - store writes also copy into wiper
// - volatile select resets to zero
// - control bit 6 shutdown, defaults one
// - bit 5 reads one during store write
// - busy blocks wiper and control writes
// - three eight-bit registers, one non-volatile
// - store keeps value across power-down
// - new tap closes before old opens
// - id byte: prefix, pin bits, read flag
// - write: id, address, data, each acked
// - store write starts only after stop
// - read continues while master acks
module dpot_ctrl #(
  parameter int WRITE_CYCLES = `WC_CYCLES,
  parameter logic [4:0] ID_PREFIX = 5'h13 // arbitrary value
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // static pins
  input wire logic addrSelectHi,
  input wire logic addrSelectLo,
  input wire logic shutdownPinN,
  // factory clear of the non-volatile cell
  input wire logic nvErase,
  // switch array control
  output logic [6:0] tapMakeSel,
  output logic [6:0] tapBreakSel,
  output logic potShutdown
);

  localparam int NVRD = `NVRD_CYCLES;

  logic [4:0] pinS;
  logic sclS, sdaS, shutdownPinS, selHiS, selLoS;
  logic sclPrev, sdaPrev;
  logic sclRise, sclFall, startSeen, stopSeen;
  logic [7:0] pwrCnt;
  logic pwrDone, pwrLoad;
  dpot_pkg::bus_state_t stateReg;
  dpot_pkg::byte_phase_t phaseReg;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg, regAddr, rdData, accRead;
  logic readMode, sdaOeReg, sdaOutReg, idMatch, byteDone, writeStrobe;
  logic volatileSel, shutdownCtl, writeInProgress;
  logic nvPending, nvWriteReq;
  logic [7:0] nvPendData, nvData;
  logic [6:0] wiperReg, nvWiper, tapMakeReg, tapBreakReg;
  logic potShutdownReg;

  // link and static pins cross into ref_clk through two flops; nvErase goes straight to the store
  pin_sync #(.WIDTH(5), .RESET_VAL(`PIN_IDLE)) uSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinIn({scl, sdaIn, shutdownPinN, addrSelectHi, addrSelectLo}),
    .pinOut(pinS)
  );
  assign {sclS, sdaS, shutdownPinS, selHiS, selLoS} = pinS;

  // store cell and its self-timed write
  nv_store #(.WIDTH(8), .WRITE_CYCLES(WRITE_CYCLES)) uStore (
    .ref_clk(ref_clk),
    .rst(rst),
    .nvErase(nvErase),
    .writeReq(nvWriteReq),
    .writeData(nvPendData),
    .storedData(nvData),
    .busy(writeInProgress)
  );
  assign nvWiper = nvData[6:0];

  // edge history of the synchronised link lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclPrev <= `LINE_IDLE;
      sdaPrev <= `LINE_IDLE;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // link events; start/stop are data edges while scl stays high
  assign sclRise = sclS && !sclPrev;
  assign sclFall = !sclS && sclPrev;
  assign startSeen = sclS && sclPrev && sdaPrev && !sdaS;
  assign stopSeen = sclS && sclPrev && !sdaPrev && sdaS;

  // id byte: prefix, then the two select pins, then read flag
  assign idMatch = (shiftReg[7:3] == ID_PREFIX) &&
    (shiftReg[2:1] == {selHiS, selLoS});
  assign byteDone = (stateReg == dpot_pkg::RX) && sclFall &&
    (bitCnt == `BYTE_BITS);
  assign writeStrobe = byteDone && (phaseReg == dpot_pkg::PH_DATA);

  // power-up wait until the store can be read reliably
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwrCnt <= 8'h00;
      pwrDone <= 1'b0;
    end else if (!pwrDone) begin
      if (pwrCnt == 8'(NVRD - 1)) begin
        pwrDone <= 1'b1;
      end else begin
        pwrCnt <= pwrCnt + 8'h01;
      end
    end
  end
  assign pwrLoad = !pwrDone && (pwrCnt == 8'(NVRD - 1));

  // slave sequencer; starts are ignored until power-up finishes
  always_ff @(posedge ref_clk) begin
    if (rst || !pwrDone) begin
      stateReg <= dpot_pkg::IDLE;
      phaseReg <= dpot_pkg::PH_ID;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      regAddr <= 8'h00;
      readMode <= 1'b0;
      sdaOeReg <= 1'b0;
    end else if (startSeen) begin
      stateReg <= dpot_pkg::RX;
      phaseReg <= dpot_pkg::PH_ID;
      bitCnt <= 4'h0;
      sdaOeReg <= 1'b0;
    end else if (stopSeen) begin
      stateReg <= dpot_pkg::IDLE;
      sdaOeReg <= 1'b0;
    end else begin
      case (stateReg)
        dpot_pkg::IDLE: begin
          sdaOeReg <= 1'b0;
        end
        dpot_pkg::RX: begin
          if (sclRise && bitCnt != `BYTE_BITS) begin
            shiftReg <= {shiftReg[6:0], sdaS};
            bitCnt <= bitCnt + 4'h1;
          end else if (byteDone) begin
            // foreign address: stay off the line until next start
            if (phaseReg != dpot_pkg::PH_ID || idMatch) begin
              stateReg <= dpot_pkg::ACK;
              sdaOeReg <= 1'b1;
            end else begin
              stateReg <= dpot_pkg::IDLE;
            end
            if (phaseReg == dpot_pkg::PH_ID) begin
              readMode <= shiftReg[0];
            end
            if (phaseReg == dpot_pkg::PH_ADDR) begin
              regAddr <= shiftReg;
            end
          end
        end
        dpot_pkg::ACK: begin
          if (sclFall) begin
            bitCnt <= 4'h0;
            if (phaseReg == dpot_pkg::PH_ID && readMode) begin
              stateReg <= dpot_pkg::TX;
              shiftReg <= rdData;
              sdaOeReg <= !rdData[7];
            end else begin
              stateReg <= dpot_pkg::RX;
              sdaOeReg <= 1'b0;
              // extra data bytes rewrite the same address
              if (phaseReg == dpot_pkg::PH_ID) begin
                phaseReg <= dpot_pkg::PH_ADDR;
              end else begin
                phaseReg <= dpot_pkg::PH_DATA;
              end
            end
          end
        end
        dpot_pkg::TX: begin
          if (sclRise) begin
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == `BYTE_BITS) begin
              stateReg <= dpot_pkg::TXACK;
              sdaOeReg <= 1'b0;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOeReg <= !shiftReg[6];
            end
          end
        end
        dpot_pkg::TXACK: begin
          if (sclRise) begin
            if (sdaS) begin
              stateReg <= dpot_pkg::IDLE;
            end else begin
              stateReg <= dpot_pkg::TXLOAD;
            end
          end
        end
        dpot_pkg::TXLOAD: begin
          if (sclFall) begin
            stateReg <= dpot_pkg::TX;
            bitCnt <= 4'h0;
            shiftReg <= rdData;
            sdaOeReg <= !rdData[7];
          end
        end
        default: begin
          stateReg <= dpot_pkg::IDLE;
          sdaOeReg <= 1'b0;
        end
      endcase
    end
  end

  // read view of access control: low five bits always zero
  always_comb begin
    accRead = `READ_ZERO;
    accRead[`ACC_VOLATILE_BIT] = volatileSel;
    accRead[`ACC_SHUTDOWN_BIT] = shutdownCtl;
    accRead[`ACC_BUSY_BIT] = writeInProgress;
  end

  // read mux; nothing here depends on shutdown
  always_comb begin
    case (regAddr)
      `REG_WIPER: begin
        rdData = volatileSel ? {1'b0, wiperReg} : nvData;
      end
      `REG_ACCESS: begin
        rdData = accRead;
      end
      default: begin
        rdData = `READ_ZERO;
      end
    endcase
  end

  // access control bits; frozen while the store is busy
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      volatileSel <= `VOLATILE_RESET;
      shutdownCtl <= `SHUTDOWN_RESET;
    end else if (writeStrobe && !writeInProgress &&
                 regAddr == `REG_ACCESS) begin
      volatileSel <= shiftReg[`ACC_VOLATILE_BIT];
      shutdownCtl <= shiftReg[`ACC_SHUTDOWN_BIT];
    end
  end

  // store write is held pending and launched by the stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvPending <= 1'b0;
      nvPendData <= `NV_BLANK;
    end else if (writeStrobe && !writeInProgress && !volatileSel &&
                 regAddr == `REG_WIPER) begin
      nvPending <= 1'b1;
      nvPendData <= shiftReg;
    end else if (stopSeen) begin
      nvPending <= 1'b0;
    end
  end
  assign nvWriteReq = stopSeen && nvPending;

  // wiper: preset, then recall, then serial writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wiperReg <= `WIPER_PRESET;
    end else if (pwrLoad) begin
      wiperReg <= nvWiper;
    end else if (writeStrobe && !writeInProgress &&
                 regAddr == `REG_WIPER) begin
      wiperReg <= shiftReg[6:0];
    end
  end

  // tap index equals wiper code, so 7Fh sits at the high terminal;
  // break follows make one cycle late so the array is never open
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tapMakeReg <= `WIPER_PRESET;
      tapBreakReg <= `WIPER_PRESET;
    end else begin
      tapMakeReg <= wiperReg;
      tapBreakReg <= tapMakeReg;
    end
  end

  // shutdown only gates the array; wiper code stays intact
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      potShutdownReg <= 1'b0;
      sdaOutReg <= 1'b0;
    end else begin
      potShutdownReg <= !(shutdownPinS && shutdownCtl);
      sdaOutReg <= 1'b0;
    end
  end

  assign sdaOut = sdaOutReg;
  assign sdaOe = sdaOeReg;
  assign tapMakeSel = tapMakeReg;
  assign tapBreakSel = tapBreakReg;
  assign potShutdown = potShutdownReg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence sNvStart;
    nvWriteReq;
  endsequence
  sequence sNvBusy;
    writeInProgress [*8];
  endsequence

  AST_PRESET: assert property (
    $fell(rst) |-> wiperReg == `WIPER_PRESET)
    else $error("wiper not preset after reset");
  AST_RECALL: assert property (
    $rose(pwrDone) |-> wiperReg == $past(nvWiper))
    else $error("wiper not recalled from store");
  AST_SHUTDOWN: assert property (
    (!shutdownCtl || !shutdownPinS) |=> potShutdown)
    else $error("shutdown not entered");
  AST_MAKE_BREAK: assert property (
    $changed(tapMakeSel) |=> tapBreakSel == $past(tapMakeSel))
    else $error("old tap not held one cycle");
  AST_BUSY_BLOCK: assert property (
    (writeStrobe && writeInProgress) |=>
      $stable(wiperReg) && $stable(volatileSel) && $stable(shutdownCtl))
    else $error("write taken while store busy");
  AST_NV_BUSY: assert property (
    sNvStart |=> sNvBusy)
    else $error("busy flag not raised by store write");
  AST_NV_STOP: assert property (
    nvWriteReq |-> stopSeen && $past(nvPending))
    else $error("store write without stop");
  AST_OPEN_DRAIN: assert property (
    !sdaOut)
    else $error("data line driven high");
  AST_SDA_EDGE: assert property (
    $changed(sdaOe) |-> $past(sclFall) || $past(startSeen) ||
      $past(stopSeen) || $past(rst))
    else $error("data line changed away from scl fall");
  AST_ID_ACK: assert property (
    (stateReg == dpot_pkg::ACK && phaseReg == dpot_pkg::PH_ID) |->
      idMatch && sdaOe)
    else $error("ack on foreign address");
  AST_COPY: assert property (
    (writeStrobe && !writeInProgress && !volatileSel &&
     regAddr == `REG_WIPER) |=> wiperReg == $past(shiftReg[6:0]))
    else $error("store value not copied to wiper");

endmodule // dpot_ctrl

// [bench/i2c_master_model.sv]
`timescale 1ns/100ps

module i2c_master_model #(
  parameter logic [4:0] ID_PREFIX = 5'h13 // arbitrary value
) (
  // clock
  input wire logic ref_clk,
  // bus lines, drvLow high pulls sda low
  output logic scl,
  output logic drvLow,
  input wire logic sda
);
  // clock idles high, line released, between frames
  initial begin
    scl = 1'b1;
    drvLow = 1'b0;
  end

  // a quarter of the 800 ns serial period
  task automatic qtr();
    repeat (2) @(negedge ref_clk);
  endtask

  // one bit, data moved only while scl is low
  task automatic bit_io(input logic b, output logic s);
    qtr();
    drvLow = !b;
    qtr();
    scl = 1'b1;
    qtr();
    s = sda;
    qtr();
    scl = 1'b0;
  endtask

  // start or repeated start, leaves scl low; the leading quarter
  // lets the slave drop its ack before scl rises again
  task automatic start();
    qtr();
    drvLow = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    drvLow = 1'b1;
    qtr();
    scl = 1'b0;
  endtask

  // stop, then bus left free and clock still
  task automatic stop();
    qtr();
    drvLow = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    drvLow = 1'b0;
    qtr();
    qtr();
  endtask

  // eight bits msb first plus the ack slot
  task automatic byte_io(input logic [7:0] tx, input logic rd,
                         input logic mAck, output logic [7:0] rx,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd | tx[i], rx[i]);
    end
    bit_io(rd ? !mAck : 1'b1, s);
    ack = !s;
  endtask

  // id, address, one data byte, stop
  task automatic reg_write(input logic [1:0] pins, input logic [7:0] addr,
                           input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    byte_io({ID_PREFIX, pins, 1'b0}, 1'b0, 1'b0, rx, a0);
    byte_io(addr, 1'b0, 1'b0, rx, a1);
    byte_io(data, 1'b0, 1'b0, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // two data bytes: first acked, last refused to end the read
  task automatic reg_read(input logic [1:0] pins, input logic [7:0] addr,
                          output logic [7:0] d0, output logic [7:0] d1,
                          output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, n;
    start();
    byte_io({ID_PREFIX, pins, 1'b0}, 1'b0, 1'b0, rx, a0);
    byte_io(addr, 1'b0, 1'b0, rx, a1);
    start();
    byte_io({ID_PREFIX, pins, 1'b1}, 1'b0, 1'b0, rx, a2);
    byte_io(8'hFF, 1'b1, 1'b1, d0, n);
    byte_io(8'hFF, 1'b1, 1'b0, d1, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // i2c_master_model

// [bench/digital_pot_register_control_bench.sv]
`timescale 1ns/100ps

`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); \
  end \
end

module digital_pot_register_control_bench;
  // long store write cut short for the run
  localparam int WRITE_CYCLES = 2000;
  localparam logic [4:0] PREFIX = 5'h0B; // arbitrary value
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [6:0] tap;
    logic shut;
  } row_t;
  logic ref_clk, rst, scl, mLow, shutdownPinN, nvErase;
  logic addrSelectHi, addrSelectLo, sdaOut, sdaOe, potShutdown, ok;
  logic [6:0] tapMakeSel, tapBreakSel, lastMake;
  logic [7:0] d0, d1;
  wire sda;
  int mismatches, checks, cycles;
  row_t rows [7] = '{
    '{8'h02, 8'hC0, 8'hC0, 7'h00, 1'b0},
    '{8'h00, 8'h7F, 8'h7F, 7'h7F, 1'b0},
    '{8'h00, 8'h00, 8'h00, 7'h00, 1'b0},
    '{8'h01, 8'h55, 8'h00, 7'h00, 1'b0},
    '{8'h02, 8'h9F, 8'h80, 7'h00, 1'b1},
    '{8'h00, 8'h33, 8'h33, 7'h33, 1'b1},
    '{8'h02, 8'hDF, 8'hC0, 7'h33, 1'b0}
  };

  // open drain line with pull-up, either party may pull low
  assign sda = (sdaOe || mLow) ? 1'b0 : 1'b1;

  dpot_ctrl #(.WRITE_CYCLES(WRITE_CYCLES), .ID_PREFIX(PREFIX)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectHi(addrSelectHi),
    .addrSelectLo(addrSelectLo), .shutdownPinN(shutdownPinN),
    .nvErase(nvErase), .tapMakeSel(tapMakeSel),
    .tapBreakSel(tapBreakSel), .potShutdown(potShutdown));

  i2c_master_model #(.ID_PREFIX(PREFIX)) model_u (
    .ref_clk(ref_clk), .scl(scl), .drvLow(mLow), .sda(sda));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog, drive level and switch overlap watched every cycle
  always @(negedge ref_clk) begin
    cycles++;
    if (sdaOe === 1'b1) `CHK("sdaOut", 1'b0, sdaOut)
    if (!rst && tapMakeSel !== lastMake)
      `CHK("tapBreakSel", lastMake, tapBreakSel)
    lastMake = tapMakeSel;
    if (cycles == 40000) begin
      mismatches++;
      close_out();
    end
  end

  // pins fixed at 10b, so the matching id uses 2'b10
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    model_u.reg_write(2'b10, a, d, ok);
    `CHK("write ack", 1'b1, ok)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    model_u.reg_read(2'b10, a, d0, d1, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK("read data", e, d0)
    `CHK("read repeat", e, d1)
  endtask

  initial begin
    rst = 1'b1;
    nvErase = 1'b1;
    shutdownPinN = 1'b1;
    addrSelectHi = 1'b1;
    addrSelectLo = 1'b0;
    cycles = 0;
    mismatches = 0;
    checks = 0;
    lastMake = 7'h40;
    repeat (10) @(negedge ref_clk);
    `CHK("tap in reset", 7'h40, tapMakeSel)
    `CHK("shutdown in reset", 1'b0, potShutdown)
    `CHK("sda in reset", 1'b0, sdaOe)
    nvErase = 1'b0;
    rst = 1'b0;
    repeat (30) @(negedge ref_clk);
    `CHK("tap after power-up", 7'h00, tapMakeSel)
    rd(8'h02, 8'h40);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
      `CHK("tap", rows[i].tap, tapMakeSel)
      `CHK("shutdown", rows[i].shut, potShutdown)
    end
    // foreign pin levels get no ack and change nothing
    model_u.reg_write(2'b01, 8'h00, 8'h11, ok);
    `CHK("foreign ack", 1'b0, ok)
    rd(8'h00, 8'h33);
    // pin side of the shutdown gate
    shutdownPinN = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHK("pin shutdown", 1'b1, potShutdown)
    shutdownPinN = 1'b1;
    repeat (6) @(negedge ref_clk);
    `CHK("pin resume", 1'b0, potShutdown)
    `CHK("tap kept", 7'h33, tapMakeSel)
    // store write, busy window blocks control writes
    wr(8'h02, 8'h40);
    wr(8'h00, 8'hA5);
    rd(8'h02, 8'h60);
    wr(8'h02, 8'hC0);
    rd(8'h02, 8'h60);
    `CHK("tap copy", 7'h25, tapMakeSel)
    repeat (WRITE_CYCLES) @(negedge ref_clk);
    rd(8'h02, 8'h40);
    rd(8'h00, 8'hA5);
    // power cycle recalls the store
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    `CHK("tap preset", 7'h40, tapMakeSel)
    rst = 1'b0;
    repeat (30) @(negedge ref_clk);
    `CHK("tap recalled", 7'h25, tapMakeSel)
    close_out();
  end
endmodule // digital_pot_register_control_bench
